// ---- design/hub_product_string_and_feature_cfg.sv ----
`timescale 1ns/10ps
// Behaviour
// R1 - Top bit of length register and bits 7:5 of feature register read zero.
// R2 - Length zero, the reset value, means no product string offered.
// R3 - Length is seven bits in bytes; at most sixty-four bytes allowed.
// R4 - Length writable only when custom text override is set.
// R5 - Non-zero length returns that many bytes at string index 3.
// R6 - Legacy bit stops advertising 5Gbps in speeds supported field.
// R7 - Legacy bit also disables the SuperSpeed hub function.
// R8 - Feature bits read and act as OR of register and fuse bit.
// R9 - Slow-rate bit selects 100kHz for USB-to-I2C requests.
// R10 - EEPROM reads run at 400K unless fuse selects 100k.
// R11 - Vendor-mode disable bit skips vendor phone charging mode.
// R12 - Full-divider bit tries all divider modes, highest first, before DCP.
// R13 - Writes to reserved bits are ignored.
module hub_product_string_and_feature_cfg (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input hub_cfg_pkg::reg_req_t req, // Register access from EEPROM or SMBus
  input wire logic req_valid, // Access strobe
  input wire logic custom_text_override, // Custom strings option
  input wire logic [4:0] fuse_bits, // Fuse copies of feature bits
  output logic [7:0] rdata, // Read data, registered
  output logic [6:0] product_text_length, // Stored product length
  output logic prod_string_present, // Product descriptor offered
  output logic [7:0] prod_string_index, // String index for product
  output logic [6:0] prod_string_bytes, // Bytes to return
  output hub_cfg_pkg::feature_ctl_t feature_ctl // Feature controls
);
  import hub_cfg_pkg::*;

  cfg_state_t state_ff;
  cfg_state_t nxt_state;
  logic [4:0] feat_eff;
  logic wr_len;
  logic wr_feat;
  logic rd_len;
  logic rd_feat;
  logic rd_other;

  // Strobed access of one kind to one offset; shared by write and read paths
  function automatic logic hit(input reg_req_t r, input logic v, input logic wr, input logic [7:0] offset);
    hit = v && (r.wr == wr) && (r.addr == offset);
  endfunction

  // Decoded accesses
  assign wr_len = hit(req, req_valid, 1'b1, PROD_LEN_OFFSET);
  assign wr_feat = hit(req, req_valid, 1'b1, FEAT_CFG_OFFSET);
  assign rd_len = hit(req, req_valid, 1'b0, PROD_LEN_OFFSET);
  assign rd_feat = hit(req, req_valid, 1'b0, FEAT_CFG_OFFSET);
  assign rd_other = req_valid && !req.wr && !rd_len && !rd_feat;

  // Effective feature bits combine register and fuse; a stray fuse on bit 3 never leaks out
  for (genvar b = 0; b < 5; b++) begin : g_eff
    assign feat_eff[b] = FEAT_CFG_MASK[b] & (state_ff.feat[b] | fuse_bits[b]); // [R8]
  end

  // Next-state: writes, clamped length, read mux
  always_comb begin
    nxt_state = state_ff;
    if (req_valid && req.wr) begin
      if (wr_len && custom_text_override) begin // [R4]
        // Oversize writes clamp so the descriptor never overruns data
        if (req.wdata[6:0] > PROD_LEN_MAX) begin // [R3]
          nxt_state.prod_len = PROD_LEN_MAX;
        end else begin
          nxt_state.prod_len = req.wdata[6:0]; // [R13]
        end
      end
      if (wr_feat) begin
        nxt_state.feat = req.wdata[4:0] & FEAT_CFG_MASK; // [R13]
      end
    end
    // Reads: reserved bits return zero
    if (req_valid && !req.wr) begin
      case (req.addr)
        PROD_LEN_OFFSET: nxt_state.rdata = {1'b0, state_ff.prod_len}; // [R1]
        FEAT_CFG_OFFSET: nxt_state.rdata = {3'h0, feat_eff}; // [R1] [R8]
        default: nxt_state.rdata = 8'h00;
      endcase
    end
    if (sys_rst) begin
      nxt_state.prod_len = PROD_LEN_RESET; // [R2]
      nxt_state.feat = FEAT_CFG_RESET;
      nxt_state.rdata = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  assign rdata = state_ff.rdata;
  assign product_text_length = state_ff.prod_len;
  assign prod_string_present = (state_ff.prod_len != 7'h00); // [R2]
  assign prod_string_index = PROD_STRING_INDEX; // [R5]
  assign prod_string_bytes = state_ff.prod_len; // [R5]

  // Feature decode for downstream engines
  always_comb begin
    feature_ctl.legacy_speed_only_report = feat_eff[LEGACY_BIT]; // [R6]
    feature_ctl.ss_hub_disable = feat_eff[LEGACY_BIT]; // [R7]
    feature_ctl.two_wire_slow_rate = feat_eff[SLOW_RATE_BIT]; // [R9]
    // EEPROM rate ignores the register bit; only the fuse slows it
    feature_ctl.eeprom_slow_rate = fuse_bits[SLOW_RATE_BIT]; // [R10]
    feature_ctl.vendor_mode_skip = feat_eff[VENDOR_DIS_BIT]; // [R11]
    feature_ctl.all_divider_auto_charge = feat_eff[FULL_DIV_BIT]; // [R12]
  end

  // Checks: length register write path

  // Without the override a length write must leave the length alone
  a_len_ro_guard: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    (req_valid && req.wr && !custom_text_override) |=> $stable(state_ff.prod_len))
    else $error("length changed without override");

  // Stored length never exceeds the descriptor limit
  a_len_max: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    state_ff.prod_len <= PROD_LEN_MAX)
    else $error("length above maximum");

  // An in-range write with override lands as written
  a_len_write_lands: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    (wr_len && custom_text_override && req.wdata[6:0] <= PROD_LEN_MAX) |=> product_text_length == $past(req.wdata[6:0]))
    else $error("length write lost");

  // An oversize write clamps to the limit
  a_len_clamp: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    (wr_len && custom_text_override && req.wdata[6:0] > PROD_LEN_MAX) |=> product_text_length == PROD_LEN_MAX)
    else $error("length not clamped");

  // Only an allowed length write may move the length
  a_len_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    !(wr_len && custom_text_override) |=> $stable(state_ff.prod_len))
    else $error("length moved unasked");

  // A feature write must not touch the length
  a_len_other_write: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    wr_feat |=> $stable(state_ff.prod_len))
    else $error("length hit by feature write");

  // Writing zero withdraws the product descriptor
  a_present_write: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    (wr_len && custom_text_override && req.wdata[6:0] == 7'h00) |=> !prod_string_present)
    else $error("descriptor still offered");

  // Checks: length register read path

  // Top bit of the length read is always zero
  a_len_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    rd_len |=> rdata[7] == 1'b0)
    else $error("length top bit nonzero");

  // Length read returns the stored value
  a_len_read_value: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    rd_len |=> rdata == {1'b0, $past(state_ff.prod_len)})
    else $error("length read wrong");

  // Read data only moves on a read
  a_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    !(req_valid && !req.wr) |=> $stable(rdata))
    else $error("read data moved");

  // Unmapped reads return zero
  a_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    rd_other |=> rdata == 8'h00)
    else $error("unmapped read nonzero");

  // Checks: descriptor outputs

  // Present flag follows a non-zero length
  a_present_len: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    prod_string_present == (product_text_length != 7'h00))
    else $error("present flag wrong");

  // Byte count equals the stored length
  a_bytes_len: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    prod_string_bytes == product_text_length)
    else $error("byte count wrong");

  // Product string always sits at its fixed index
  a_index_const: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    prod_string_index == PROD_STRING_INDEX)
    else $error("string index wrong");

  // Checks: feature register write and read

  // Feature write stores only the writable bits
  a_feat_write: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    wr_feat |=> state_ff.feat == ($past(req.wdata[4:0]) & FEAT_CFG_MASK))
    else $error("feature write wrong");

  // Features hold between writes
  a_feat_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    !wr_feat |=> $stable(state_ff.feat))
    else $error("features moved unasked");

  // Reserved bit 3 is never stored
  a_reserved_write: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    wr_feat |=> state_ff.feat[3] == 1'b0)
    else $error("reserved bit stored");

  // Feature read is the OR of register and fuse
  a_feat_read_or: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    rd_feat |=> rdata == {3'h0, ($past(state_ff.feat) | $past(fuse_bits)) & FEAT_CFG_MASK})
    else $error("feature read not OR of fuse");

  // Top three bits of the feature read are zero
  a_feat_top_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    rd_feat |=> rdata[7:5] == 3'h0)
    else $error("feature top bits nonzero");

  // Reserved bit 3 reads zero even with a stray fuse
  a_feat_reserved_read: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    rd_feat |=> rdata[3] == 1'b0)
    else $error("reserved bit read nonzero");

  // Checks: feature controls

  // Both legacy controls move together
  a_legacy_both: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    feature_ctl.ss_hub_disable == feature_ctl.legacy_speed_only_report)
    else $error("SS hub disable mismatch");

  // Legacy fuse alone forces the report
  a_legacy_fuse: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    fuse_bits[LEGACY_BIT] |-> feature_ctl.legacy_speed_only_report)
    else $error("legacy fuse ignored");

  // Legacy register bit alone forces the report
  a_legacy_reg: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    state_ff.feat[LEGACY_BIT] |-> feature_ctl.legacy_speed_only_report)
    else $error("legacy register ignored");

  // Legacy register bit disables the SuperSpeed hub
  a_ss_reg: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    state_ff.feat[LEGACY_BIT] |-> feature_ctl.ss_hub_disable)
    else $error("SS hub left on");

  // EEPROM rate ignores the register bit
  a_eeprom_rate: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (state_ff.feat[SLOW_RATE_BIT] && !fuse_bits[SLOW_RATE_BIT]) |-> !feature_ctl.eeprom_slow_rate)
    else $error("EEPROM slowed by register");

  // EEPROM rate follows the fuse exactly
  a_eeprom_fuse: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    feature_ctl.eeprom_slow_rate == fuse_bits[SLOW_RATE_BIT])
    else $error("EEPROM rate not fuse");

  // Slow rate is register OR fuse
  a_slow_rate: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    feature_ctl.two_wire_slow_rate == (state_ff.feat[SLOW_RATE_BIT] | fuse_bits[SLOW_RATE_BIT]))
    else $error("slow rate wrong");

  // Vendor skip follows the effective bit
  a_vendor_skip: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    feature_ctl.vendor_mode_skip == feat_eff[VENDOR_DIS_BIT])
    else $error("vendor skip wrong");

  // Vendor fuse alone forces the skip
  a_vendor_fuse: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    fuse_bits[VENDOR_DIS_BIT] |-> feature_ctl.vendor_mode_skip)
    else $error("vendor fuse ignored");

  // Divider control follows the effective bit
  a_full_div: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    feature_ctl.all_divider_auto_charge == feat_eff[FULL_DIV_BIT])
    else $error("divider wrong");

  // Divider fuse alone enables the sweep
  a_div_fuse: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    fuse_bits[FULL_DIV_BIT] |-> feature_ctl.all_divider_auto_charge)
    else $error("divider fuse ignored");

  // Reset clears every register
  a_reset_clears: assert property (@(posedge clk) // [R2]
    sys_rst |=> (product_text_length == 7'h00 && state_ff.feat == 5'h00 && rdata == 8'h00))
    else $error("reset left state");

  // Main scenarios
  c_len_write: cover property (@(posedge clk) wr_len && custom_text_override);
  c_len_clamp: cover property (@(posedge clk) wr_len && custom_text_override && req.wdata[6:0] > PROD_LEN_MAX);
  c_feat_read: cover property (@(posedge clk) rd_feat);
  c_fuse_or: cover property (@(posedge clk) rd_feat && fuse_bits != 5'h00);
  c_legacy_on: cover property (@(posedge clk) feature_ctl.legacy_speed_only_report);
endmodule

// ---- inc/hub_cfg_pkg.sv ----
package hub_cfg_pkg;
  // Register offsets
  localparam logic [7:0] PROD_LEN_OFFSET = 8'h24;
  localparam logic [7:0] FEAT_CFG_OFFSET = 8'h25;
  // Reset values
  localparam logic [6:0] PROD_LEN_RESET = 7'h00;
  localparam logic [4:0] FEAT_CFG_RESET = 5'h00;
  // Feature bits that hold storage; bit 3 is reserved
  localparam logic [4:0] FEAT_CFG_MASK = 5'h17;
  // Field positions in the feature register
  localparam int FULL_DIV_BIT = 0;
  localparam int VENDOR_DIS_BIT = 1;
  localparam int SLOW_RATE_BIT = 2;
  localparam int LEGACY_BIT = 4;
  // Limits and descriptor codes
  localparam logic [6:0] PROD_LEN_MAX = 7'h40;
  localparam logic [7:0] PROD_STRING_INDEX = 8'h03;
  // I2C clock rates in kHz
  localparam int RATE_FAST_KHZ = 400;
  localparam int RATE_SLOW_KHZ = 100;

  // Register access request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Decoded feature controls
  typedef struct packed {
    logic legacy_speed_only_report;
    logic ss_hub_disable;
    logic two_wire_slow_rate;
    logic eeprom_slow_rate;
    logic vendor_mode_skip;
    logic all_divider_auto_charge;
  } feature_ctl_t;

  // Whole module state
  typedef struct packed {
    logic [6:0] prod_len;
    logic [4:0] feat;
    logic [7:0] rdata;
  } cfg_state_t;
endpackage

// ---- tb/hub_cfg_host_model.sv ----
`timescale 1ns/10ps
// Host or EEPROM loader; one access per strobe
module hub_cfg_host_model (
  input wire logic clk, // Core clock
  output hub_cfg_pkg::reg_req_t req, // Register access
  output logic req_valid // Access strobe
);
  import hub_cfg_pkg::*;
  initial begin
    req = '0;
    req_valid = 1'b0;
  end
  // Held to the taking edge; released lines flip so stale data never looks valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    req <= '{wr: wr, addr: addr, wdata: wdata};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req <= '{wr: 1'b0, addr: ~addr, wdata: ~wdata};
    @(posedge clk);
  endtask
endmodule

// ---- tb/hub_product_string_and_feature_cfg_tb_top.sv ----
`timescale 1ns/10ps
module hub_product_string_and_feature_cfg_tb_top;
  import hub_cfg_pkg::*;
  typedef struct packed {logic ovr; logic [4:0] fuse; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic custom_text_override = 1'b0;
  logic [4:0] fuse_bits = 5'h00;
  reg_req_t req;
  logic req_valid;
  logic [7:0] rdata;
  logic [6:0] product_text_length;
  logic prod_string_present;
  logic [7:0] prod_string_index;
  logic [6:0] prod_string_bytes;
  feature_ctl_t feature_ctl;
  logic [7:0] e;
  int n_mismatch = 0;
  int check_count = 0;
  // Write then read back; last row hits an unmapped offset
  row_t rows [8] = '{'{1'b1, 5'h00, 8'h24, 8'h05, 8'h05}, '{1'b0, 5'h00, 8'h24, 8'h07, 8'h05},
    '{1'b1, 5'h00, 8'h24, 8'hff, 8'h40}, '{1'b1, 5'h00, 8'h24, 8'h00, 8'h00},
    '{1'b0, 5'h00, 8'h25, 8'hff, 8'h17}, '{1'b0, 5'h15, 8'h25, 8'h00, 8'h15},
    '{1'b0, 5'h04, 8'h25, 8'h02, 8'h06}, '{1'b0, 5'h00, 8'h30, 8'haa, 8'h00}};
  always #2.5 clk = ~clk;
  hub_cfg_host_model u_hub_cfg_host_model (.clk(clk), .req(req), .req_valid(req_valid));
  hub_product_string_and_feature_cfg u_hub_product_string_and_feature_cfg (.clk(clk), .sys_rst(sys_rst),
    .req(req), .req_valid(req_valid), .custom_text_override(custom_text_override), .fuse_bits(fuse_bits),
    .rdata(rdata), .product_text_length(product_text_length), .prod_string_present(prod_string_present),
    .prod_string_index(prod_string_index), .prod_string_bytes(prod_string_bytes), .feature_ctl(feature_ctl));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run needs under 100 cycles
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    u_hub_cfg_host_model.access(1'b0, PROD_LEN_OFFSET, 8'h00);
    #1;
    chk("reset length", 8'h00, rdata);
    @(posedge clk);
    foreach (rows[i]) begin
      e = rows[i].exp;
      custom_text_override <= rows[i].ovr;
      fuse_bits <= rows[i].fuse;
      u_hub_cfg_host_model.access(1'b1, rows[i].addr, rows[i].wdata);
      u_hub_cfg_host_model.access(1'b0, rows[i].addr, 8'h00);
      #1;
      chk("rdata", e, rdata);
      if (rows[i].addr == PROD_LEN_OFFSET) begin
        chk("present", {7'h00, e != 8'h00}, {7'h00, prod_string_present});
        chk("bytes", e, {1'b0, prod_string_bytes});
        chk("index", 8'h03, prod_string_index);
      end
      if (rows[i].addr == FEAT_CFG_OFFSET) begin
        chk("features", {2'b00, e[4], e[4], e[2], rows[i].fuse[2], e[1], e[0]},
          {2'b00, feature_ctl});
      end
      $display("row %0d done", i);
      @(posedge clk);
    end
    // Reset again in mid-run with length and features stored
    custom_text_override <= 1'b1;
    u_hub_cfg_host_model.access(1'b1, PROD_LEN_OFFSET, 8'h09);
    #1;
    chk("length before reset", 8'h09, {1'b0, product_text_length});
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("features", 8'h00, {2'b00, feature_ctl});
    chk("length", 8'h00, {1'b0, product_text_length});
    $display("reset test done");
    stop_test();
  end
endmodule
